// ==== dotc_pkg.sv ====
// Purpose: shared constants for the test and debug register bank and its core-side port
// Assumes: one 40 MHz clock, asynchronous active-low reset
// Notes: coprocessor selectors are opcode_1, crn, crm, opcode_2 of a transfer
package dotc_pkg;
  localparam int unsigned DOTC_DW = 32;
  // coprocessor selector values
  localparam logic [2:0] DOTC_OP1_BANK0 = 3'h0;
  localparam logic [2:0] DOTC_OP1_BANK1 = 3'h1;
  localparam logic [3:0] DOTC_CRN_TEST = 4'hF;
  localparam logic [3:0] DOTC_CRM_OVR = 4'h0;
  localparam logic [3:0] DOTC_CRM_ADDR = 4'h1;
  localparam logic [2:0] DOTC_OP2_ZERO = 3'h0;
  // override register fields
  localparam int unsigned DOTC_OVR_CLEAN_ALL = 19;
  localparam int unsigned DOTC_OVR_ABT_DTB = 18;
  localparam int unsigned DOTC_OVR_ABT_ITB = 17;
  localparam int unsigned DOTC_OVR_NO_PREF = 16;
  localparam int unsigned DOTC_OVR_NO_CGATE = 15;
  localparam int unsigned DOTC_OVR_FORCE_UB = 14;
  localparam int unsigned DOTC_OVR_MMUOFF_WRTHRU = 13;
  localparam logic [31:0] DOTC_OVR_MASK = 32'h000FE000;
  localparam logic [31:0] DOTC_OVR_RESET = 32'h00000000;
  localparam logic [31:0] DOTC_ADDR_RESET = 32'h00000000;
  // trace stall control fields
  localparam int unsigned DOTC_TRC_FAST = 2;
  localparam int unsigned DOTC_TRC_NORM = 1;
  localparam logic [31:0] DOTC_TRC_MASK = 32'h00000006;
  localparam logic [31:0] DOTC_TRC_RESET = 32'h00000000;
  // translation fault status value
  localparam logic [3:0] DOTC_FS_TRANSLATION = 4'h0;
  // data attribute encodings
  typedef enum logic [1:0] {
    DOTC_ATTR_UNCACHED_UNBUFFERED,
    DOTC_ATTR_UNCACHED_BUFFERED,
    DOTC_ATTR_WRITE_THROUGH,
    DOTC_ATTR_WRITE_BACK
  } dotc_attr_e;
  // apb register offsets of the core-side command port
  localparam logic [7:0] DOTC_REG_CMD = 8'h00;
  localparam logic [7:0] DOTC_REG_WDATA = 8'h04;
  localparam logic [7:0] DOTC_REG_RDATA = 8'h08;
  localparam logic [7:0] DOTC_REG_STATUS = 8'h0C;
  localparam logic [31:0] DOTC_APB_ERRDATA = 32'h00000000;
endpackage : dotc_pkg

// ==== dotc_if.sv ====
// Purpose: coprocessor transfer link between core end and register bank
// Assumes: single clock, transfer is a one-cycle strobe
// Notes: read data answers one cycle after the strobe
`timescale 1ns/1ps
interface dotc_if;
  logic cp_valid; // one-cycle transfer strobe
  logic cp_write; // direction bit, 1 write, 0 read
  logic [2:0] cp_op1;
  logic [3:0] cp_crn;
  logic [3:0] cp_crm;
  logic [2:0] cp_op2;
  logic [31:0] cp_wdata;
  logic cp_rvalid; // read data answer pulse
  logic cp_hit; // register decoded
  logic [31:0] cp_rdata;
  modport bank (input cp_valid, cp_write, cp_op1, cp_crn, cp_crm, cp_op2, cp_wdata,
                output cp_rvalid, cp_hit, cp_rdata);
  modport core (output cp_valid, cp_write, cp_op1, cp_crn, cp_crm, cp_op2, cp_wdata,
                input cp_rvalid, cp_hit, cp_rdata);
endinterface : dotc_if

// ==== dotc_bank.sv ====
// Purpose: test and debug register bank with override and trace stall control
// Assumes: core signals are on i_clk; interrupt and queue-full pins are asynchronous
// Notes: reserved override and trace bits read as zero
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dotc_bank
  import dotc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  dotc_if.bank cp,
  input wire logic i_trace_queue_full, // async pin
  input wire logic i_fast_interrupt_n, // async pin, active low
  input wire logic i_normal_interrupt_n, // async pin, active low
  input wire logic i_dtb_miss, // data translation buffer miss
  input wire logic i_itb_miss, // instr translation buffer miss
  input wire logic i_spec_fetch_req, // speculative noncachable fetch wanted
  input wire logic i_core_fetch_req, // core-issued instruction fetch
  input wire logic i_mmu_en,
  input wire logic i_dcache_en,
  input wire logic i_remap_valid, // region remap register gives attribute
  input wire logic [1:0] i_remap_attr,
  input wire logic [1:0] i_page_attr, // data attribute from page tables
  input wire logic i_clean_req, // test-and-clean style operation
  output logic [31:0] o_debug_override,
  output logic [31:0] o_test_address,
  output logic o_core_stall,
  output logic o_dtb_abort,
  output logic o_itb_abort,
  output logic o_walk_start,
  output logic o_fault_we,
  output logic [3:0] o_fault_status,
  output logic o_bus_fetch,
  output logic o_cgate_en,
  output logic [1:0] o_data_attr,
  output logic [1:0] o_store_attr,
  output logic o_clean_all
);
  logic [31:0] ovr_q; // override register, reserved bits kept zero
  logic [31:0] addr_q; // test address register
  logic [31:0] trc_q; // trace stall control
  logic [2:0] s1_q; // first sync stage: full, fast, normal
  logic [2:0] s2_q; // second sync stage
  logic sel_ovr;
  logic sel_addr;
  logic sel_trc;
  logic fast_pend;
  logic norm_pend;
  logic stall_d;
  logic [1:0] attr_d;
  logic [1:0] sattr_d;

  // decode of the coprocessor selectors
  // opcode_2 must be zero for all three registers; any other
  // selector decodes to nothing, so a write to it is dropped
  assign sel_ovr = cp.cp_op1 == DOTC_OP1_BANK0 && cp.cp_crn == DOTC_CRN_TEST &&
                   cp.cp_crm == DOTC_CRM_OVR && cp.cp_op2 == DOTC_OP2_ZERO;
  assign sel_addr = cp.cp_op1 == DOTC_OP1_BANK0 && cp.cp_crn == DOTC_CRN_TEST &&
                    cp.cp_crm == DOTC_CRM_ADDR && cp.cp_op2 == DOTC_OP2_ZERO;
  assign sel_trc = cp.cp_op1 == DOTC_OP1_BANK1 && cp.cp_crn == DOTC_CRN_TEST &&
                   cp.cp_crm == DOTC_CRM_ADDR && cp.cp_op2 == DOTC_OP2_ZERO;

  // register writes; reserved bits are masked so they always read zero
  // the test address register keeps all 32 bits, since it has no
  // reserved field of its own
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovr_q <= DOTC_OVR_RESET;
      addr_q <= DOTC_ADDR_RESET;
      trc_q <= DOTC_TRC_RESET;
    end else if (cp.cp_valid && cp.cp_write) begin
      if (sel_ovr) begin
        ovr_q <= cp.cp_wdata & DOTC_OVR_MASK;
      end
      if (sel_addr) begin
        addr_q <= cp.cp_wdata;
      end
      if (sel_trc) begin
        trc_q <= cp.cp_wdata & DOTC_TRC_MASK;
      end
    end
  end

  // read answer one cycle after a read strobe; unmapped reads give zero and no hit
  // read data holds until the next read, so a slow poller still finds it;
  // the hit flag pulses with any strobe to a mapped selector, write or read
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cp.cp_rvalid <= 1'b0;
      cp.cp_hit <= 1'b0;
      cp.cp_rdata <= 32'h00000000;
    end else begin
      cp.cp_rvalid <= cp.cp_valid && !cp.cp_write;
      cp.cp_hit <= cp.cp_valid && (sel_ovr || sel_addr || sel_trc);
      if (cp.cp_valid && !cp.cp_write) begin
        cp.cp_rdata <= sel_ovr ? ovr_q : sel_addr ? addr_q : sel_trc ? trc_q : 32'h00000000;
      end
    end
  end

  // two-flop synchronisers for the asynchronous pins
  // the queue-full and interrupt pins come from outside this clock,
  // so only the second stage is ever read by logic
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {i_trace_queue_full, !i_fast_interrupt_n, !i_normal_interrupt_n};
      s2_q <= s1_q;
    end
  end

  // a pending interrupt only blocks the stall while its control bit is clear
  // the pins reach the stall output three edges after they move, so a
  // very short interrupt pulse may never lift a stall
  assign fast_pend = s2_q[1] && !trc_q[DOTC_TRC_FAST];
  assign norm_pend = s2_q[0] && !trc_q[DOTC_TRC_NORM];
  assign stall_d = s2_q[2] && !fast_pend && !norm_pend;

  // data attribute with mmu off; remap wins over write-through
  // with the mmu on the page tables decide alone; the encodings
  // follow dotc_attr_e
  always_comb begin
    attr_d = DOTC_ATTR_UNCACHED_UNBUFFERED;
    if (i_mmu_en) begin
      attr_d = i_page_attr;
    end else if (i_remap_valid) begin
      attr_d = i_remap_attr;
    end else if (ovr_q[DOTC_OVR_MMUOFF_WRTHRU] && i_dcache_en) begin
      attr_d = DOTC_ATTR_WRITE_THROUGH;
    end
    // store attribute: force override beats page tables and remap
    sattr_d = attr_d;
    if (ovr_q[DOTC_OVR_FORCE_UB] && attr_d == DOTC_ATTR_UNCACHED_BUFFERED) begin
      sattr_d = DOTC_ATTR_UNCACHED_UNBUFFERED;
    end
  end

  // registered control outputs; a miss either walks or aborts, never both
  // fault status is the translation code for every aborted miss;
  // the fault write strobe tells the core when to store it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_stall <= 1'b0;
      o_dtb_abort <= 1'b0;
      o_itb_abort <= 1'b0;
      o_walk_start <= 1'b0;
      o_fault_we <= 1'b0;
      o_fault_status <= DOTC_FS_TRANSLATION;
      o_bus_fetch <= 1'b0;
      o_cgate_en <= 1'b1;
      o_data_attr <= 2'h0;
      o_store_attr <= 2'h0;
      o_clean_all <= 1'b0;
    end else begin
      o_core_stall <= stall_d;
      o_dtb_abort <= i_dtb_miss && ovr_q[DOTC_OVR_ABT_DTB];
      o_itb_abort <= i_itb_miss && ovr_q[DOTC_OVR_ABT_ITB];
      o_walk_start <= (i_dtb_miss && !ovr_q[DOTC_OVR_ABT_DTB]) ||
                      (i_itb_miss && !ovr_q[DOTC_OVR_ABT_ITB]);
      o_fault_we <= (i_dtb_miss && ovr_q[DOTC_OVR_ABT_DTB]) ||
                    (i_itb_miss && ovr_q[DOTC_OVR_ABT_ITB]);
      o_fault_status <= DOTC_FS_TRANSLATION;
      o_bus_fetch <= i_core_fetch_req ||
                     (i_spec_fetch_req && !ovr_q[DOTC_OVR_NO_PREF]);
      o_cgate_en <= !ovr_q[DOTC_OVR_NO_CGATE];
      o_data_attr <= attr_d;
      o_store_attr <= sattr_d;
      o_clean_all <= i_clean_req && ovr_q[DOTC_OVR_CLEAN_ALL];
    end
  end

  // mirror the registers for the surrounding logic
  // these copies lag the registers by one edge, which the
  // surrounding logic must allow for
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_debug_override <= DOTC_OVR_RESET;
      o_test_address <= DOTC_ADDR_RESET;
    end else begin
      o_debug_override <= ovr_q;
      o_test_address <= addr_q;
    end
  end
endmodule : dotc_bank

// ==== dotc_core.sv ====
// Purpose: core end issuing coprocessor transfers, ordered by software over apb
// Assumes: apb on i_clk, zero-wait slave
// Notes: one transfer at a time; status busy after a read until the bank answers
`timescale 1ns/1ps
module dotc_core
  import dotc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  dotc_if.core cp
);
  logic [31:0] wdata_q; // data for next write transfer
  logic [31:0] rdata_q; // last read answer
  logic busy_q; // read waiting for answer
  logic hit_q; // last answer decoded
  logic acc;
  logic known;

  assign acc = i_psel && i_penable;
  assign known = i_paddr == DOTC_REG_CMD || i_paddr == DOTC_REG_WDATA ||
                 i_paddr == DOTC_REG_RDATA || i_paddr == DOTC_REG_STATUS;

  // apb answer: ready every access phase, error on unmapped offsets
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= DOTC_APB_ERRDATA;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !known;
      case (i_paddr)
        DOTC_REG_WDATA: o_prdata <= wdata_q;
        DOTC_REG_RDATA: o_prdata <= rdata_q;
        DOTC_REG_STATUS: o_prdata <= {30'h0, hit_q, busy_q};
        default: o_prdata <= DOTC_APB_ERRDATA;
      endcase
    end
  end

  // command word: [0] write, [3:1] op2, [7:4] crm, [11:8] crn, [14:12] op1
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cp.cp_valid <= 1'b0;
      cp.cp_write <= 1'b0;
      cp.cp_op1 <= 3'h0;
      cp.cp_crn <= 4'h0;
      cp.cp_crm <= 4'h0;
      cp.cp_op2 <= 3'h0;
      cp.cp_wdata <= 32'h00000000;
      wdata_q <= 32'h00000000;
    end else begin
      cp.cp_valid <= 1'b0;
      if (acc && o_pready && i_pwrite && i_paddr == DOTC_REG_WDATA) begin
        wdata_q <= i_pwdata;
      end
      if (acc && o_pready && i_pwrite && i_paddr == DOTC_REG_CMD && !busy_q) begin
        cp.cp_valid <= 1'b1;
        cp.cp_write <= i_pwdata[0];
        cp.cp_op2 <= i_pwdata[3:1];
        cp.cp_crm <= i_pwdata[7:4];
        cp.cp_crn <= i_pwdata[11:8];
        cp.cp_op1 <= i_pwdata[14:12];
        cp.cp_wdata <= wdata_q;
      end
    end
  end

  // track read answers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_q <= 1'b0;
      hit_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (cp.cp_rvalid) begin
      busy_q <= 1'b0;
      hit_q <= cp.cp_hit;
      rdata_q <= cp.cp_rdata;
    end else if (cp.cp_valid && !cp.cp_write) begin
      busy_q <= 1'b1;
    end
  end
endmodule : dotc_core

// ==== dotc_properties.sv ====
// Purpose: link checks between the core end and the register bank
// Assumes: one clock, active-low asynchronous reset, strobe protocol of dotc_if
// Notes: sees only the link wires, so bank side effects are judged by the bench
`timescale 1ns/1ps
module dotc_properties
  import dotc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [2:0] cp_op1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_op2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_rvalid,
  input wire logic cp_hit,
  input wire logic [31:0] cp_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // common part of every mapped selector
  logic sel_c15;
  assign sel_c15 = cp_valid && cp_crn == DOTC_CRN_TEST && cp_op2 == DOTC_OP2_ZERO;
  // one strobe per mapped register
  sequence s_ovr; sel_c15 && cp_op1 == DOTC_OP1_BANK0 && cp_crm == DOTC_CRM_OVR; endsequence
  sequence s_adr; sel_c15 && cp_op1 == DOTC_OP1_BANK0 && cp_crm == DOTC_CRM_ADDR; endsequence
  sequence s_trc; sel_c15 && cp_op1 == DOTC_OP1_BANK1 && cp_crm == DOTC_CRM_ADDR; endsequence
  // a read of the override register followed by its answer
  sequence s_rd_ovr; s_ovr ##0 !cp_write ##1 cp_rvalid; endsequence
  property p_rd_ans; cp_valid && !cp_write |=> cp_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
  property p_wr_quiet; cp_valid && cp_write |=> !cp_rvalid; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write answered as read");
  property p_idle_quiet; !cp_valid |=> !cp_rvalid; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without strobe");
  property p_hit_ovr; s_ovr |=> cp_hit; endproperty
  a_hit_ovr: assert property (p_hit_ovr) else $error("override not decoded");
  property p_hit_adr; s_adr |=> cp_hit; endproperty
  a_hit_adr: assert property (p_hit_adr) else $error("address not decoded");
  property p_hit_trc; s_trc |=> cp_hit; endproperty
  a_hit_trc: assert property (p_hit_trc) else $error("trace control not decoded");
  property p_hit_miss; cp_valid && cp_crn != DOTC_CRN_TEST |=> !cp_hit; endproperty
  a_hit_miss: assert property (p_hit_miss) else $error("foreign selector decoded");
  property p_ovr_rsvd; s_rd_ovr |-> (cp_rdata & ~DOTC_OVR_MASK) == 32'h00000000; endproperty
  a_ovr_rsvd: assert property (p_ovr_rsvd) else $error("reserved override bits set");
endmodule : dotc_properties

// ==== testbench.sv ====
// Purpose: self-checking bench for core end, bank and the link between them
// Assumes: 40 MHz clock, zero-wait apb answer, registered bank outputs
// Notes: apb reads note expectations in a queue; a monitor pops and compares
`timescale 1ns/1ps
module testbench;
  import dotc_pkg::*;
  logic i_clk, i_arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ov, tr, mon_e, mon_m, rd, w32, tad, ovr;
  logic full, fast_n, norm_n, dmiss, imiss, spec, cfetch, mmu, dce, rmv, clr, exp_err;
  logic stall, dab, iab, walk, fwe, bfetch, cg, call;
  logic [1:0] rma, pga, dat, sat, da;
  logic [3:0] fst;
  logic [31:0] exp_q[$], msk_q[$]; // expected read data and compare mask
  int err_total, n_compared, seed_dummy;
  dotc_if lnk();
  dotc_core dotc_core_i(.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .cp(lnk.core));
  dotc_bank dotc_bank_i(.i_clk(i_clk), .i_arst_n(i_arst_n), .cp(lnk.bank),
    .i_trace_queue_full(full), .i_fast_interrupt_n(fast_n), .i_normal_interrupt_n(norm_n),
    .i_dtb_miss(dmiss), .i_itb_miss(imiss), .i_spec_fetch_req(spec),
    .i_core_fetch_req(cfetch), .i_mmu_en(mmu), .i_dcache_en(dce), .i_remap_valid(rmv),
    .i_remap_attr(rma), .i_page_attr(pga), .i_clean_req(clr), .o_debug_override(ovr),
    .o_test_address(tad), .o_core_stall(stall), .o_dtb_abort(dab), .o_itb_abort(iab),
    .o_walk_start(walk), .o_fault_we(fwe), .o_fault_status(fst), .o_bus_fetch(bfetch),
    .o_cgate_en(cg), .o_data_attr(dat), .o_store_attr(sat), .o_clean_all(call));
  dotc_properties dotc_properties_i(.i_clk(i_clk), .i_arst_n(i_arst_n),
    .cp_valid(lnk.cp_valid), .cp_write(lnk.cp_write), .cp_op1(lnk.cp_op1),
    .cp_crn(lnk.cp_crn), .cp_crm(lnk.cp_crm), .cp_op2(lnk.cp_op2), .cp_wdata(lnk.cp_wdata),
    .cp_rvalid(lnk.cp_rvalid), .cp_hit(lnk.cp_hit), .cp_rdata(lnk.cp_rdata));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, output logic [31:0] r);
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // no count of wait states is assumed; only the watchdog ends a wait
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // coprocessor transfer ordered over apb; busy is polled before the answer is read
  task automatic cp(input logic w, input logic [2:0] o1, input logic [3:0] crn,
                    input logic [3:0] crm, input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] r;
    apb(1'b1, DOTC_REG_WDATA, d, '0, '0, r);
    apb(1'b1, DOTC_REG_CMD, {17'h0, o1, crn, crm, DOTC_OP2_ZERO, w}, '0, '0, r);
    do begin
      apb(1'b0, DOTC_REG_STATUS, '0, '0, '0, r);
    end while (r[0] !== 1'b0);
    if (!w) begin
      apb(1'b0, DOTC_REG_RDATA, '0, e, m, r);
    end
  endtask : cp
  // read monitor: oldest note against the data taken at the completing edge
  always @(posedge i_clk) begin
    // every completed transfer: only the four mapped offsets answer without error
    if (psel && penable && pready === 1'b1) begin
      exp_err = !(paddr inside {DOTC_REG_CMD, DOTC_REG_WDATA, DOTC_REG_RDATA, DOTC_REG_STATUS});
      n_compared++;
      if (pslverr !== exp_err) begin
        err_total++;
        $display("Error pslverr expected %b seen %b", exp_err, pslverr);
      end
    end
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_m = msk_q.pop_front();
      if (mon_m != 32'h0) begin
        n_compared++;
        if ((prdata & mon_m) !== (mon_e & mon_m)) begin
          err_total++;
          $display("Error prdata expected %h seen %h", mon_e & mon_m, prdata & mon_m);
        end
      end
    end
  end
  // watchdog: 40000 cycles, far beyond the roughly 1100 cycles the tests need
  initial begin
    #(25 * 40000);
    err_total++;
    complete_run();
  end
  initial begin
    {i_arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {full, dmiss, imiss, spec, cfetch, mmu, dce, rmv, clr, rma, pga} = '0;
    fast_n = 1'b1;
    norm_n = 1'b1;
    seed_dummy = $urandom(79);
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    cp(1'b0, DOTC_OP1_BANK0, DOTC_CRN_TEST, DOTC_CRM_OVR, '0, DOTC_OVR_RESET, '1);
    cp(1'b0, DOTC_OP1_BANK1, DOTC_CRN_TEST, DOTC_CRM_ADDR, '0, '0, DOTC_TRC_MASK);
    chk("cgate_reset", 32'h1, cg);
    $display("test reset values done");
    w32 = $urandom;
    cp(1'b1, DOTC_OP1_BANK0, DOTC_CRN_TEST, DOTC_CRM_OVR, ~32'h0, '0, '0);
    cp(1'b0, DOTC_OP1_BANK0, DOTC_CRN_TEST, DOTC_CRM_OVR, '0, DOTC_OVR_MASK, '1);
    cp(1'b1, DOTC_OP1_BANK0, DOTC_CRN_TEST, DOTC_CRM_ADDR, w32, '0, '0);
    cp(1'b0, DOTC_OP1_BANK0, DOTC_CRN_TEST, DOTC_CRM_ADDR, '0, w32, '1);
    chk("test_address", w32, tad);
    cp(1'b1, DOTC_OP1_BANK1, DOTC_CRN_TEST, DOTC_CRM_ADDR, ~w32 & DOTC_TRC_MASK, '0, '0);
    cp(1'b0, DOTC_OP1_BANK1, DOTC_CRN_TEST, DOTC_CRM_ADDR, '0, ~w32, DOTC_TRC_MASK);
    cp(1'b0, DOTC_OP1_BANK0, 4'h7, DOTC_CRM_OVR, '0, '0, '1);
    apb(1'b0, 8'h10, '0, '0, '1, rd);
    $display("test register access done");
    // random override, trace control and pin levels; outputs checked once settled
    for (int k = 0; k < 40; k++) begin
      ov = $urandom & DOTC_OVR_MASK;
      tr = $urandom & DOTC_TRC_MASK;
      cp(1'b1, DOTC_OP1_BANK0, DOTC_CRN_TEST, DOTC_CRM_OVR, ov, '0, '0);
      cp(1'b1, DOTC_OP1_BANK1, DOTC_CRN_TEST, DOTC_CRM_ADDR, tr, '0, '0);
      @(posedge i_clk);
      {full, fast_n, norm_n, dmiss, imiss, spec, cfetch, mmu, dce, rmv, clr, rma, pga} <=
        15'($urandom);
      repeat (5) @(posedge i_clk);
      chk("override", ov, ovr);
      chk("stall", full & ~(~fast_n & ~tr[2]) & ~(~norm_n & ~tr[1]), stall);
      chk("dtb_abort", dmiss & ov[18], dab);
      chk("itb_abort", imiss & ov[17], iab);
      chk("walk", (dmiss & ~ov[18]) | (imiss & ~ov[17]), walk);
      chk("fault_we", (dmiss & ov[18]) | (imiss & ov[17]), fwe);
      chk("fault_status", DOTC_FS_TRANSLATION, fst);
      chk("bus_fetch", cfetch | (spec & ~ov[16]), bfetch);
      chk("cgate", !ov[15], cg);
      chk("clean_all", clr & ov[19], call);
      // mmu off: remap first, then write-through (2) if enabled, else unbuffered (0)
      da = mmu ? pga : (rmv ? rma : ((ov[13] && dce) ? 2'h2 : 2'h0));
      chk("data_attr", da, dat);
      // forcing applies after page tables and remap have chosen the attribute
      chk("store_attr", (da == 2'h1 && ov[14]) ? 2'h0 : da, sat);
    end
    $display("test random overrides done");
    complete_run();
  end
endmodule : testbench
